// *** dv/crl_host_model.sv ***
module crl_host_model (
    input wire logic addr20_override,
    input wire logic kbc_addr20_gate,
    input wire logic cpu_reset_line,
    input wire logic disk_changed,
    output logic cpu_addr20_mask_n,
    output logic media_change_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Board glue: any high source lifts the mask input.
    assign cpu_addr20_mask_n = addr20_override | kbc_addr20_gate
        | cpu_reset_line;
    // The drive's change line; held low it also straps the diskette absent.
    assign media_change_in = disk_changed;
endmodule : crl_host_model

// *** dv/crl_top_sva.sv ***
module crl_chk
    import crl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic media_change_in,
    input wire logic cpu_soft_reset_n_ff,
    input wire logic addr20_override_ff,
    input wire logic sys_data_bit7_out_ff,
    input wire logic sys_data_bit7_oe_ff,
    input wire logic aux_bus_buffer_oe_n_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Write strobe aimed at the system control port.
    wire logic cw = reg_wr && reg_addr == SYS_CTRL_OFFSET;
    chk_pulse_len: assert property ($fell(cpu_soft_reset_n_ff) |->
        !cpu_soft_reset_n_ff [*4] ##1 cpu_soft_reset_n_ff) else $error("bad pulse");
    chk_pulse_cause: assert property ($fell(cpu_soft_reset_n_ff) |->
        $past(cw && reg_wdata[0])) else $error("pulse without write");
    // Reset itself must be checked, so the default disable is overridden.
    chk_reset_init: assert property (disable iff (1'b0) reset |=>
        cpu_soft_reset_n_ff && !addr20_override_ff && !sys_data_bit7_oe_ff
        && aux_bus_buffer_oe_n_ff) else $error("bad reset state");
    chk_a20_follow: assert property (cw |=>
        addr20_override_ff == $past(reg_wdata[1])) else $error("a20 wrong");
    chk_a20_hold: assert property (!cw |=>
        $stable(addr20_override_ff)) else $error("a20 moved");
    chk_bit7_val: assert property (sys_data_bit7_oe_ff |->
        sys_data_bit7_out_ff == !media_change_in) else $error("bit7 wrong");
    chk_oe_cause: assert property (sys_data_bit7_oe_ff |->
        $past(io_rd && (io_addr == DISK_STAT_PRIMARY ||
        io_addr == DISK_STAT_SECONDARY)) && aux_bus_buffer_oe_n_ff)
        else $error("bit7 driven without status read");
    chk_buf_excl: assert property (!aux_bus_buffer_oe_n_ff |->
        $past(io_rd) && !sys_data_bit7_oe_ff) else $error("buffer clash");
    cover property ($fell(cpu_soft_reset_n_ff));
    cover property (sys_data_bit7_oe_ff);
    cover property (!aux_bus_buffer_oe_n_ff);
endmodule : crl_chk

bind crl_top crl_chk u_chk (.*);

// *** dv/tb_crl_top.sv ***
module tb_crl_top;
    timeunit 1ns;
    timeprecision 100ps;
    import crl_pkg::*;
    logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, io_rd = 0;
    logic disk = 1, gate = 0, crst = 0, mcin, mask_n, n_ff, a20, b7, oe, bn;
    logic [7:0] reg_addr = 0, reg_wdata = 0, rdata;
    logic [15:0] io_addr = 0;
    int err_count = 0, tests_run = 0, ctl, cfg, present = 1;
    always #12.5 clk = ~clk;
    crl_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(rdata), .io_addr(io_addr), .io_rd(io_rd),
        .media_change_in(mcin), .cpu_soft_reset_n_ff(n_ff),
        .addr20_override_ff(a20), .sys_data_bit7_out_ff(b7),
        .sys_data_bit7_oe_ff(oe), .aux_bus_buffer_oe_n_ff(bn));
    crl_host_model host (.addr20_override(a20), .kbc_addr20_gate(gate),
        .cpu_reset_line(crst), .disk_changed(disk),
        .cpu_addr20_mask_n(mask_n), .media_change_in(mcin));
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Callers sit on an edge; the strobe drops after the taking edge.
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk(rdata, exp);
        @(posedge clk);
    endtask : rd
    // Counts low cycles in a fixed window; a stuck-low line ends the run.
    task automatic pulse(input int exp);
        int cnt = 0;
        repeat (8) begin
            #1 if (n_ff === 1'b0) cnt++;
            @(posedge clk);
        end
        chk(cnt, exp);
        if (n_ff !== 1'b1) begin
            err_count++;
            end_sim();
        end
    endtask : pulse
    task automatic io(input logic [15:0] a);
        logic hit = present && cfg[0] &&
            a == (cfg[2] ? DISK_STAT_SECONDARY : DISK_STAT_PRIMARY);
        io_addr <= a;
        io_rd <= 1;
        repeat (2) @(posedge clk);
        #1 chk({oe, oe & b7, bn}, {hit & !cfg[1], hit & !cfg[1] & !disk,
            !(hit & cfg[1])});
        io_rd <= 0;
        @(posedge clk);
    endtask : io
    initial begin
        void'($urandom(19761));
        repeat (8) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        rd(SYS_CTRL_OFFSET, 0);
        #1 chk({n_ff, a20, oe, bn}, 4'b1001);
        rd(8'h55, 0);
        $display("reset test done");
        wr(SYS_CTRL_OFFSET, 1);
        pulse(4);
        wr(SYS_CTRL_OFFSET, 1);
        pulse(0);
        wr(SYS_CTRL_OFFSET, 0);
        pulse(0);
        wr(SYS_CTRL_OFFSET, 1);
        pulse(4);
        rd(SYS_CTRL_OFFSET, 1);
        $display("pulse test done");
        repeat (6) begin
            ctl = $urandom & 2;
            gate <= 1'($urandom);
            crst <= 1'($urandom);
            wr(SYS_CTRL_OFFSET, 8'(ctl));
            #1 chk(a20, ctl[1]);
            chk(mask_n, ctl[1] | gate | crst);
            @(posedge clk);
        end
        $display("a20 test done");
        for (int c = 0; c < 8; c++) begin
            cfg = c;
            disk <= 1'($urandom);
            wr(DECODE_CFG_OFFSET, 8'(c));
            repeat (8) @(posedge clk);
            io(DISK_STAT_PRIMARY);
            io(DISK_STAT_SECONDARY);
        end
        rd(DECODE_CFG_OFFSET, 7);
        rd(STATUS_OFFSET, 1);
        $display("status test done");
        disk <= 0;
        reset <= 1;
        repeat (8) @(posedge clk);
        reset <= 0;
        present = 0;
        cfg = 1;
        @(posedge clk);
        rd(STATUS_OFFSET, 0);
        wr(DECODE_CFG_OFFSET, 1);
        @(posedge clk);
        io(DISK_STAT_PRIMARY);
        $display("strap test done");
        end_sim();
    end
endmodule : tb_crl_top

// *** rtl/crl_pkg.sv ***
package crl_pkg;
    // Register bus widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // System control port, and a configuration register and a status register of our own.
    localparam logic [7:0] SYS_CTRL_OFFSET = 8'h92;
    localparam logic [7:0] DECODE_CFG_OFFSET = 8'h40;
    localparam logic [7:0] STATUS_OFFSET = 8'h41;
    // Field positions.
    localparam int RST_REQ_BIT = 0;
    localparam int A20_BIT = 1;
    localparam int FLOP_EN_BIT = 0;
    localparam int DRV_EN_BIT = 1;
    localparam int SECONDARY_BIT = 2;
    localparam int PRESENT_BIT = 0;
    // Reset values.
    localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
    localparam logic [7:0] DECODE_CFG_RESET = 8'h00;
    // Diskette status I/O locations.
    localparam logic [15:0] DISK_STAT_PRIMARY = 16'h03F7;
    localparam logic [15:0] DISK_STAT_SECONDARY = 16'h0377;
    // Soft reset pulse: four ISA system clock periods.
    localparam int PULSE_SYSCLKS = 4;
    localparam logic [2:0] PULSE_LEN = 3'h4;
    // Pulse states, Gray coded from PS_IDLE to PS_WAIT_CLEAR; the return flips both bits.
    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_PULSE = 2'b01,
        PS_WAIT_CLEAR = 2'b11
    } crl_pulse_type;
endpackage : crl_pkg

// *** rtl/crl_sync.sv ***
// Three-stage synchroniser; a change is accepted once stages two and three
// agree, which filters a single-cycle glitch on the pin.
module crl_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_ff
);
    logic [2:0] stage_ff;
    logic [2:0] nxt_stage;
    logic nxt_level;

    ////////////////////////////////////////////////////////////////////////
    // Shift the pin in; stage 0 feeds only stage 1.
    always_comb begin
        nxt_stage = {stage_ff[1:0], pin_in};
        nxt_level = level_ff;
        if (stage_ff[1] == stage_ff[2]) begin
            nxt_level = stage_ff[2];
        end
    end

    // Register the stages and the filtered level. The stages keep sampling
    // through reset, so the level already shows the pin when reset ends.
    // Clearing them here would make the presence strap, caught at the first
    // edge after release, always read the diskette as absent.
    always_ff @(posedge clk) begin
        if (reset) begin
            stage_ff <= nxt_stage;
            level_ff <= stage_ff[2];
        end else begin
            stage_ff <= nxt_stage;
            level_ff <= nxt_level;
        end
    end
endmodule : crl_sync

// *** rtl/crl_top.sv ***
module crl_top
    import crl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [crl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [crl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [crl_pkg::DATA_W-1:0] reg_rdata_ff,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic media_change_in,
    output logic cpu_soft_reset_n_ff,
    output logic addr20_override_ff,
    output logic sys_data_bit7_out_ff,
    output logic sys_data_bit7_oe_ff,
    output logic aux_bus_buffer_oe_n_ff
);
    import crl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0] sys_ctrl_ff; // System control port.
    logic [7:0] nxt_sys_ctrl;
    logic [7:0] decode_cfg_ff; // Diskette decode configuration.
    logic [7:0] nxt_decode_cfg;
    logic [7:0] nxt_rdata;
    crl_pulse_type pulse_ff; // Soft reset pulse sequencer.
    crl_pulse_type nxt_pulse;
    logic [2:0] count_ff; // Cycles left in the pulse.
    logic [2:0] nxt_count;
    logic nxt_soft_reset_n;
    logic present_ff; // Diskette present strap.
    logic nxt_present;
    logic strap_pending_ff; // Strap still to be caught after reset.
    logic media_sync; // Filtered media change level.
    logic nxt_bit7_out;
    logic nxt_bit7_oe;
    logic nxt_buf_oe_n;
    logic status_hit;

    // Decode of a register address, used by both write and read paths.
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // Media change pin comes from outside the clock domain.
    crl_sync u_sync (
        .clk(clk),
        .reset(reset),
        .pin_in(media_change_in),
        .level_ff(media_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes and reads. Unmapped reads return zero.
    always_comb begin
        nxt_sys_ctrl = sys_ctrl_ff;
        nxt_decode_cfg = decode_cfg_ff;
        nxt_rdata = 8'h00;
        if (reg_wr) begin
            if (reg_hit(reg_addr, SYS_CTRL_OFFSET)) begin
                nxt_sys_ctrl = reg_wdata;
            end
            if (reg_hit(reg_addr, DECODE_CFG_OFFSET)) begin
                nxt_decode_cfg = {5'h00, reg_wdata[2:0]};
            end
        end
        if (reg_rd) begin
            if (reg_hit(reg_addr, SYS_CTRL_OFFSET)) begin
                nxt_rdata = sys_ctrl_ff;
            end else if (reg_hit(reg_addr, DECODE_CFG_OFFSET)) begin
                nxt_rdata = decode_cfg_ff;
            end else if (reg_hit(reg_addr, STATUS_OFFSET)) begin
                nxt_rdata = {7'h00, present_ff};
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    // Register file; reset clears the reset request and override bits.
    always_ff @(posedge clk) begin
        if (reset) begin
            sys_ctrl_ff <= SYS_CTRL_RESET;
            decode_cfg_ff <= DECODE_CFG_RESET;
            reg_rdata_ff <= 8'h00;
        end else begin
            sys_ctrl_ff <= nxt_sys_ctrl;
            decode_cfg_ff <= nxt_decode_cfg;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft reset pulse. The pulse fires on the write that sets bit 0, then
    // waits until software clears the bit, so holding bit 0 at one cannot
    // keep resetting the CPU.
    always_comb begin
        nxt_pulse = pulse_ff;
        nxt_count = count_ff;
        nxt_soft_reset_n = 1'b1;
        case (pulse_ff)
            PS_IDLE: begin
                if (nxt_sys_ctrl[RST_REQ_BIT]) begin
                    nxt_pulse = PS_PULSE;
                    nxt_count = PULSE_LEN - 3'h1;
                    nxt_soft_reset_n = 1'b0;
                end
            end
            PS_PULSE: begin
                if (count_ff == 3'h0) begin
                    nxt_pulse = PS_WAIT_CLEAR;
                end else begin
                    nxt_count = count_ff - 3'h1;
                    nxt_soft_reset_n = 1'b0;
                end
            end
            PS_WAIT_CLEAR: begin
                if (!sys_ctrl_ff[RST_REQ_BIT]) begin
                    nxt_pulse = PS_IDLE;
                end
            end
            default: begin
                nxt_pulse = PS_IDLE;
            end
        endcase
    end

    // Sequencer registers; output idles high through reset.
    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_ff <= PS_IDLE;
            count_ff <= 3'h0;
            cpu_soft_reset_n_ff <= 1'b1;
            addr20_override_ff <= 1'b0;
        end else begin
            pulse_ff <= nxt_pulse;
            count_ff <= nxt_count;
            cpu_soft_reset_n_ff <= nxt_soft_reset_n;
            // The board ORs this with the keyboard gate and CPU reset.
            addr20_override_ff <= nxt_sys_ctrl[A20_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diskette status read path. The strap is caught by a clocked process
    // after reset release, once the synchroniser has settled.
    always_comb begin
        nxt_present = present_ff;
        if (strap_pending_ff) begin
            nxt_present = media_sync;
        end
        // Location chosen by the configuration register.
        if (decode_cfg_ff[SECONDARY_BIT]) begin
            status_hit = io_rd && (io_addr == DISK_STAT_SECONDARY);
        end else begin
            status_hit = io_rd && (io_addr == DISK_STAT_PRIMARY);
        end
        nxt_bit7_out = 1'b0;
        nxt_bit7_oe = 1'b0;
        nxt_buf_oe_n = 1'b1;
        if (status_hit && present_ff &&
            decode_cfg_ff[FLOP_EN_BIT]) begin
            if (decode_cfg_ff[DRV_EN_BIT]) begin
                nxt_buf_oe_n = 1'b0;
            end else begin
                nxt_bit7_out = ~media_sync;
                nxt_bit7_oe = 1'b1;
            end
        end
    end

    // Output and strap registers; all drives off in reset.
    always_ff @(posedge clk) begin
        if (reset) begin
            present_ff <= 1'b0;
            strap_pending_ff <= 1'b1;
            sys_data_bit7_out_ff <= 1'b0;
            sys_data_bit7_oe_ff <= 1'b0;
            aux_bus_buffer_oe_n_ff <= 1'b1;
        end else begin
            present_ff <= nxt_present;
            strap_pending_ff <= 1'b0;
            sys_data_bit7_out_ff <= nxt_bit7_out;
            sys_data_bit7_oe_ff <= nxt_bit7_oe;
            aux_bus_buffer_oe_n_ff <= nxt_buf_oe_n;
        end
    end
endmodule : crl_top
